// File: plsbg_pkg.sv
// Package: register map, field positions, reset values and types
package plsbg_pkg;

    // ************************************************************
    // Register offsets (byte addresses on APB)
    // ************************************************************
    localparam logic [7:0] PLSBG_OFF_CTRL   = 8'h00;  // pll_control_reg
    localparam logic [7:0] PLSBG_OFF_BW     = 8'h04;  // pll_bandwidth_reg
    localparam logic [7:0] PLSBG_OFF_BFC    = 8'h08;  // break_flag_control_reg
    localparam logic [7:0] PLSBG_OFF_IRQ_ST = 8'h0C;  // Sticky event status, read only
    localparam logic [7:0] PLSBG_OFF_IRQ_EN = 8'h10;  // Event enable
    localparam logic [7:0] PLSBG_OFF_IRQ_CL = 8'h14;  // Event clear, write only

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PLSBG_CTRL_IE_BIT   = 7;   // PLL interrupt enable
    localparam int PLSBG_CTRL_FLAG_BIT = 6;   // pll_flag
    localparam int PLSBG_BW_AUTO_BIT   = 7;
    localparam int PLSBG_BW_LOCK_BIT   = 6;
    localparam int PLSBG_BW_TRK_BIT    = 5;
    localparam int PLSBG_BFC_BREAK_CLEAR_FLAG_ENABLE_BIT  = 7;   // break_clear_flag_enable
    localparam int PLSBG_EV_LOCK_BIT   = 0;   // Lock change event
    localparam int PLSBG_EV_TRK_BIT    = 1;   // Tracking entry event

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0]  PLSBG_CTRL_RST = 8'h00;
    localparam logic [7:0]  PLSBG_BW_RST   = 8'h00;
    localparam logic [7:0]  PLSBG_BFC_RST  = 8'h00;
    localparam logic [1:0]  PLSBG_EV_RST   = 2'h0;
    localparam int          PLSBG_N_ACQ    = 32;   // Tracking-entry window, ref cycles
    localparam int          PLSBG_N_TRK    = 128;  // Lock-entry window, ref cycles
    localparam int          PLSBG_CNT_W    = 16;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic in_trk_tol;   // Averaged error inside tracking tolerance
        logic in_lock_tol;  // Averaged error inside lock tolerance
    } plsbg_tol_t;

    typedef enum logic [1:0] {
        PLSBG_ACQ,
        PLSBG_TRK,
        PLSBG_LOCKED
    } plsbg_state_t;

endpackage : plsbg_pkg

// File: plsbg_window.sv
// Qualification window: judges a whole window of reference cycles
`timescale 1ns/1ns
module plsbg_window
    import plsbg_pkg::*;
#(
    parameter int N = 32
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Control
    input  wire logic run_i,      // Window runs while high
    input  wire logic ref_tick_i, // One divided-reference cycle
    input  wire logic in_tol_i,   // Error within tolerance this cycle
    // Result
    output logic      pass_o      // Pulse: whole window was in tolerance
);

    logic [PLSBG_CNT_W-1:0] cnt_q;
    logic                   good_q;

    // whole-window judgement
    // Count N reference cycles, judge whole window, then restart
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= '0;
            good_q <= 1'b1;
            pass_o <= 1'b0;
        end else begin
            pass_o <= 1'b0;
            if (!run_i) begin
                cnt_q  <= '0;
                good_q <= 1'b1;
            end else if (ref_tick_i) begin
                if (cnt_q == PLSBG_CNT_W'(N - 1)) begin
                    pass_o <= good_q & in_tol_i;
                    cnt_q  <= '0;
                    good_q <= 1'b1;
                end else begin
                    cnt_q  <= cnt_q + 1'b1;
                    good_q <= good_q & in_tol_i;
                end
            end
        end
    end

endmodule : plsbg_window

// File: plsbg_ref_tick.sv
// Edge detector turning the divided reference level into cycle ticks
`timescale 1ns/1ns
module plsbg_ref_tick (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Reference level
    input  wire logic divided_reference_clock_i,
    // Tick
    output logic      tick_o
);

    logic prev_q;

    // Rising edge of reference gives one tick
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_q <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            prev_q <= divided_reference_clock_i;
            tick_o <= divided_reference_clock_i & ~prev_q;
        end
    end

endmodule : plsbg_ref_tick

// File: plsbg_top.sv
// PLL lock status and break guard for the flag, with APB registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module plsbg_top
    import plsbg_pkg::*;
#(
    parameter int N_ACQ = PLSBG_N_ACQ,
    parameter int N_TRK = PLSBG_N_TRK
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // PLL side
    input  wire logic        divided_reference_clock_i,
    input  wire logic        pll_on_i,
    input  wire plsbg_tol_t  tol_i,
    input  wire logic        break_active_i,
    // Status outputs
    output logic             trk_mode_o,  // PLL in tracking bandwidth
    output logic             lock_o,      // Lock indication
    output logic             irq_o        // Level interrupt
);

    // ************************************************************
    // Declarations
    // ************************************************************
    plsbg_state_t state_q;
    logic         auto_q;
    logic         man_trk_q;    // Manual tracking choice, kept across auto
    logic         lock_q;
    logic         pll_ie_q;
    logic         pll_flag_q;
    logic         break_clear_flag_enable_q;
    logic [1:0]   ev_st_q;
    logic [1:0]   ev_en_q;
    logic         tick;
    logic         acq_pass;
    logic         lock_pass;
    logic         run_acq;
    logic         run_lock;
    logic         lock_d;
    logic         trk_d;
    logic         wr_en;
    logic         rd_en;
    logic         clr_ok;
    logic [1:0]   ev_set;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Bus strobes: single-cycle access phase
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pwrite_i;

    // clear gate
    // Clearing allowed outside break, or in break with clear-enable
    assign clr_ok = ~break_active_i | break_clear_flag_enable_q;

    // ************************************************************
    // Reference tick and qualification windows
    // ************************************************************
    plsbg_ref_tick u_tick (
        .ref_clk_i                 (ref_clk_i),
        .rstn_i                    (rstn_i),
        .divided_reference_clock_i (divided_reference_clock_i),
        .tick_o                    (tick)
    );

    assign run_acq  = auto_q & pll_on_i & (state_q == PLSBG_ACQ);
    assign run_lock = auto_q & pll_on_i & (state_q == PLSBG_TRK);

    plsbg_window #(
        .N (N_ACQ)
    ) u_acq_win (
        .ref_clk_i  (ref_clk_i),
        .rstn_i     (rstn_i),
        .run_i      (run_acq),
        .ref_tick_i (tick),
        .in_tol_i   (tol_i.in_trk_tol),
        .pass_o     (acq_pass)
    );

    plsbg_window #(
        .N (N_TRK)
    ) u_lock_win (
        .ref_clk_i  (ref_clk_i),
        .rstn_i     (rstn_i),
        .run_i      (run_lock),
        .ref_tick_i (tick),
        .in_tol_i   (tol_i.in_lock_tol),
        .pass_o     (lock_pass)
    );

    // ************************************************************
    // Acquisition state machine
    // ************************************************************
    // window multiples
    // State advances only at a window end, so times are whole windows
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= PLSBG_ACQ;
        end else if (!auto_q || !pll_on_i) begin
            state_q <= PLSBG_ACQ;
        end else begin
            case (state_q)
                PLSBG_ACQ: begin
                    if (acq_pass) begin
                        state_q <= PLSBG_TRK;
                    end
                end
                PLSBG_TRK: begin
                    if (lock_pass) begin
                        state_q <= PLSBG_LOCKED;
                    end
                end
                PLSBG_LOCKED: begin
                    // Lost lock tolerance drops back to tracking
                    if (tick && !tol_i.in_lock_tol) begin
                        state_q <= PLSBG_TRK;
                    end
                end
                default: begin
                    state_q <= PLSBG_ACQ;
                end
            endcase
        end
    end

    assign trk_d  = auto_q ? (state_q != PLSBG_ACQ) : man_trk_q;
    assign lock_d = auto_q & (state_q == PLSBG_LOCKED);

    // Registered status outputs
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_q     <= 1'b0;
            trk_mode_o <= 1'b0;
            lock_o     <= 1'b0;
        end else begin
            lock_q     <= lock_d;
            trk_mode_o <= trk_d;
            lock_o     <= lock_d;
        end
    end

    // ************************************************************
    // Control register writes
    // ************************************************************
    // Mode, manual tracking choice, enables, clear-enable
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            auto_q    <= PLSBG_BW_RST[PLSBG_BW_AUTO_BIT];
            man_trk_q <= PLSBG_BW_RST[PLSBG_BW_TRK_BIT];
            pll_ie_q  <= PLSBG_CTRL_RST[PLSBG_CTRL_IE_BIT];
            break_clear_flag_enable_q    <= PLSBG_BFC_RST[PLSBG_BFC_BREAK_CLEAR_FLAG_ENABLE_BIT];
            ev_en_q   <= PLSBG_EV_RST;
        end else if (wr_en) begin
            if (hit(paddr_i, PLSBG_OFF_BW)) begin
                auto_q <= pwdata_i[PLSBG_BW_AUTO_BIT];
                if (!auto_q) begin
                    man_trk_q <= pwdata_i[PLSBG_BW_TRK_BIT];
                end
            end
            if (hit(paddr_i, PLSBG_OFF_CTRL)) begin
                pll_ie_q <= pwdata_i[PLSBG_CTRL_IE_BIT];
            end
            if (hit(paddr_i, PLSBG_OFF_BFC)) begin
                break_clear_flag_enable_q <= pwdata_i[PLSBG_BFC_BREAK_CLEAR_FLAG_ENABLE_BIT];
            end
            if (hit(paddr_i, PLSBG_OFF_IRQ_EN)) begin
                ev_en_q <= pwdata_i[1:0];
            end
        end
    end

    // ************************************************************
    // PLL flag
    // ************************************************************
    // set on lock change, zero in manual
    // clear by reading control register, gated in break
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_flag_q <= PLSBG_CTRL_RST[PLSBG_CTRL_FLAG_BIT];
        end else if (!auto_q) begin
            pll_flag_q <= 1'b0;
        end else if (lock_d != lock_q) begin
            pll_flag_q <= 1'b1;
        end else if (rd_en && hit(paddr_i, PLSBG_OFF_CTRL) && clr_ok) begin
            pll_flag_q <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupt status, enable and clear
    // ************************************************************
    assign ev_set[PLSBG_EV_LOCK_BIT] = auto_q & (lock_d != lock_q);
    assign ev_set[PLSBG_EV_TRK_BIT]  = auto_q & acq_pass & (state_q == PLSBG_ACQ);

    // Set wins over clear; clear also obeys the break gate
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ev_st_q <= PLSBG_EV_RST;
        end else if (wr_en && hit(paddr_i, PLSBG_OFF_IRQ_CL) && clr_ok) begin
            ev_st_q <= (ev_st_q & ~pwdata_i[1:0]) | ev_set;
        end else begin
            ev_st_q <= ev_st_q | ev_set;
        end
    end

    // Interrupt from enabled events or enabled pll flag
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (|(ev_st_q & ev_en_q)) | (pll_flag_q & pll_ie_q);
        end
    end

    // ************************************************************
    // APB read and response
    // ************************************************************
    // Zero-wait answer; unmapped offsets give an error
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    PLSBG_OFF_CTRL: begin
                        prdata_o[PLSBG_CTRL_IE_BIT]   <= pll_ie_q;
                        prdata_o[PLSBG_CTRL_FLAG_BIT] <= pll_flag_q;
                    end
                    PLSBG_OFF_BW: begin
                        prdata_o[PLSBG_BW_AUTO_BIT] <= auto_q;
                        prdata_o[PLSBG_BW_LOCK_BIT] <= lock_d;
                        prdata_o[PLSBG_BW_TRK_BIT]  <= trk_d;
                    end
                    PLSBG_OFF_BFC: begin
                        prdata_o[PLSBG_BFC_BREAK_CLEAR_FLAG_ENABLE_BIT] <= break_clear_flag_enable_q;
                    end
                    PLSBG_OFF_IRQ_ST: begin
                        prdata_o[1:0] <= ev_st_q;
                    end
                    PLSBG_OFF_IRQ_EN: begin
                        prdata_o[1:0] <= ev_en_q;
                    end
                    PLSBG_OFF_IRQ_CL: begin
                        prdata_o <= 32'h0000_0000;
                    end
                    default: begin
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_flag_hold_break;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (break_active_i && !break_clear_flag_enable_q && pll_flag_q && auto_q && lock_d == lock_q)
            |=> pll_flag_q;
    endproperty
    a_flag_hold_break: assert property (p_flag_hold_break)
        else $error("flag lost during protected break");

    property p_flag_clear_break;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (break_active_i && break_clear_flag_enable_q && rd_en && hit(paddr_i, PLSBG_OFF_CTRL)
            && auto_q && lock_d == lock_q) |=> !pll_flag_q;
    endproperty
    a_flag_clear_break: assert property (p_flag_clear_break)
        else $error("flag not cleared in break with clear-enable");

    property p_stays_clear;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (!pll_flag_q && $fell(break_active_i) && lock_d == lock_q) |=> !pll_flag_q;
    endproperty
    a_stays_clear: assert property (p_stays_clear)
        else $error("flag restored after break");

    property p_flag_on_change;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (auto_q && lock_d != lock_q) |=> pll_flag_q;
    endproperty
    a_flag_on_change: assert property (p_flag_on_change)
        else $error("flag not set on lock change");

    property p_manual_zero;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !auto_q |=> !pll_flag_q && !lock_o;
    endproperty
    a_manual_zero: assert property (p_manual_zero)
        else $error("flag or lock set in manual mode");

    property p_trk_after_pass;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (acq_pass && auto_q && pll_on_i && state_q == PLSBG_ACQ) |=> ##1 trk_mode_o;
    endproperty
    a_trk_after_pass: assert property (p_trk_after_pass)
        else $error("tracking bit not set after window");

    property p_lock_needs_win;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(state_q == PLSBG_LOCKED) |-> $past(lock_pass);
    endproperty
    a_lock_needs_win: assert property (p_lock_needs_win)
        else $error("lock without qualified window");

    property p_lock_out;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (auto_q && state_q == PLSBG_LOCKED) |=> lock_o;
    endproperty
    a_lock_out: assert property (p_lock_out)
        else $error("lock output not set");

    property p_trk_needs_win;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(state_q == PLSBG_TRK) && $past(state_q) == PLSBG_ACQ |-> $past(acq_pass);
    endproperty
    a_trk_needs_win: assert property (p_trk_needs_win)
        else $error("tracking without qualified window");

endmodule : plsbg_top

// File: plsbg_top_bench.sv
// Self-checking bench for the lock status and break guard block
`timescale 1ns/1ns
module plsbg_top_bench
    import plsbg_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam int NA = 4;
    localparam int NT = 8;
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ref_q   = 1'b0;
    logic [1:0]  div_q   = 2'h0;
    logic        pll_on  = 1'b0;
    logic        brk     = 1'b0;
    plsbg_tol_t  tol     = '0;
    logic        trk_mode_o;
    logic        lock_o;
    logic        irq_o;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          compares  = 0;
    int          seed      = 30147;
    int          cyc       = 0;

    plsbg_top #(.N_ACQ(NA), .N_TRK(NT)) uut (
        .ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .divided_reference_clock_i(ref_q), .pll_on_i(pll_on), .tol_i(tol), .break_active_i(brk),
        .trk_mode_o(trk_mode_o), .lock_o(lock_o), .irq_o(irq_o)
    );

    // Clock, reference of one cycle per four clocks, timeout
    always #5 clk = ~clk;
    always @(posedge clk) begin
        div_q <= div_q + 2'h1;
        ref_q <= div_q[1];
        cyc   <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Expected bandwidth word from mode, lock and tracking bits
    function automatic logic [31:0] bw_word(input logic au, input logic lk, input logic tr);
        bw_word                    = 32'h0000_0000;
        bw_word[PLSBG_BW_AUTO_BIT] = au;
        bw_word[PLSBG_BW_LOCK_BIT] = lk;
        bw_word[PLSBG_BW_TRK_BIT]  = tr;
    endfunction : bw_word

    // APB transfer, held until pready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask : rdchk

    task ticks(input int n);
        repeat (4 * n) @(posedge clk);
    endtask : ticks

    // Wait bounded for the tracking (0) or lock (1) output to reach v
    task wait_out(input bit lk, input logic v, input int maxc);
        int n;
        n = 0;
        while (((lk ? lock_o : trk_mode_o) !== v) && n < maxc) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < maxc), 32'h0000_0001);
    endtask : wait_out

    task stop_test;
        $display("Counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] d;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        // Reset values and unmapped access
        for (int i = 0; i < 4; i++) begin
            rdchk(8'(i * 4), 32'h0000_00FF, 32'h0000_0000);
        end
        chk({trk_mode_o, lock_o, irq_o}, 32'h0000_0000);
        apb(1'b1, 8'h18, 32'h0000_00FF);
        chk(er, 1'b1);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            apb(1'b1, PLSBG_OFF_IRQ_EN, d);
            rdchk(PLSBG_OFF_IRQ_EN, 32'h0000_0003, d & 32'h0000_0003);
        end
        apb(1'b1, PLSBG_OFF_IRQ_EN, 32'h0000_0000);
        $display("test reset done");
        // Manual mode: tracking bit writable, flag reads zero
        apb(1'b1, PLSBG_OFF_BW, 32'h0000_0020);
        rdchk(PLSBG_OFF_BW, 32'h0000_00E0, bw_word(1'b0, 1'b0, 1'b1));
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0000);
        ticks(2 * NT);
        chk(lock_o, 1'b0);
        apb(1'b1, PLSBG_OFF_BW, 32'h0000_0000);
        $display("test manual done");
        // Auto mode acquisition and lock
        apb(1'b1, PLSBG_OFF_BW, 32'h0000_0080);
        tol    <= '{in_trk_tol: 1'b1, in_lock_tol: 1'b1};
        pll_on <= 1'b1;
        ticks(NA - 1);
        chk(trk_mode_o, 1'b0);
        wait_out(1'b0, 1'b1, 12 * NA);
        ticks(NT - 1);
        chk(lock_o, 1'b0);
        wait_out(1'b1, 1'b1, 12 * NT);
        apb(1'b1, PLSBG_OFF_BW, 32'h0000_0080);
        rdchk(PLSBG_OFF_BW, 32'h0000_00E0, bw_word(1'b1, 1'b1, 1'b1));
        rdchk(PLSBG_OFF_IRQ_ST, 32'h0000_0003, 32'h0000_0003);
        chk(irq_o, 1'b0);
        $display("test lock done");
        // Break with clear-enable at zero keeps flag and status
        brk <= 1'b1;
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
        apb(1'b1, PLSBG_OFF_CTRL, 32'h0000_0000);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
        apb(1'b1, PLSBG_OFF_IRQ_CL, 32'h0000_0003);
        apb(1'b1, PLSBG_OFF_IRQ_EN, 32'h0000_0001);
        rdchk(PLSBG_OFF_IRQ_ST, 32'h0000_0003, 32'h0000_0003);
        chk(irq_o, 1'b1);
        apb(1'b1, PLSBG_OFF_IRQ_EN, 32'h0000_0000);
        ticks(1);
        chk(irq_o, 1'b0);
        // Break with clear-enable at one, clears survive break exit
        apb(1'b1, PLSBG_OFF_BFC, 32'h0000_0080);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0000);
        apb(1'b1, PLSBG_OFF_IRQ_CL, 32'h0000_0003);
        rdchk(PLSBG_OFF_IRQ_ST, 32'h0000_0003, 32'h0000_0000);
        brk <= 1'b0;
        ticks(2);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0000);
        rdchk(PLSBG_OFF_IRQ_ST, 32'h0000_0003, 32'h0000_0000);
        apb(1'b1, PLSBG_OFF_BFC, 32'h0000_0000);
        $display("test break done");
        // Lock loss and regain each raise the flag
        apb(1'b1, PLSBG_OFF_CTRL, 32'h0000_0080);
        tol <= '{in_trk_tol: 1'b1, in_lock_tol: 1'b0};
        wait_out(1'b1, 1'b0, 16);
        repeat (3) @(posedge clk);
        chk({trk_mode_o, irq_o}, 32'h0000_0003);
        rdchk(PLSBG_OFF_IRQ_ST, 32'h0000_0003, 32'h0000_0001);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
        repeat (2) @(posedge clk);
        chk(irq_o, 1'b0);
        tol <= '{in_trk_tol: 1'b1, in_lock_tol: 1'b1};
        wait_out(1'b1, 1'b1, 12 * NT);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
        apb(1'b1, PLSBG_OFF_BW, 32'h0000_0000);
        rdchk(PLSBG_OFF_CTRL, 32'h0000_0040, 32'h0000_0000);
        $display("test relock done");
        stop_test();
    end
endmodule : plsbg_top_bench
